// ==== rscc_board_model.sv ====
// board strap resistors and external host master
// assumes the bench picks strap levels and master drive values
`timescale 1ns/100ps
`default_nettype none
module rscc_board_model
  import rscc_pkg::*;
(
  input wire logic nrst,
  input wire rscc_straps_t straps,
  input wire logic cs_n_drv,
  input wire logic mosi_drv,
  input wire logic hi_out,
  input wire logic hi_oe,
  input wire logic sda_oe,
  output logic test_pin,
  output logic ac_lo_pin,
  output logic ac_hi_pin,
  output logic if_lo_pin,
  output logic if_hi_pin,
  output logic sda_pin
);
  // ****************************************
  // straps and master drive
  // ****************************************
  assign test_pin = straps.test;
  assign ac_lo_pin = straps.auto_cfg[0];
  assign ac_hi_pin = straps.auto_cfg[1];
  // only a serial board has a master on the select line; others keep the resistor
  logic ser_board = 1'b0;
  always @(posedge nrst) ser_board = (straps.host_if == 2'h3);
  assign if_lo_pin = (nrst && ser_board) ? cs_n_drv : straps.host_if[0];
  // resistor level shows whenever the device lets go
  assign if_hi_pin = hi_oe ? hi_out : straps.host_if[1];
  // open drain: device only pulls low, else master or pull-up
  assign sda_pin = sda_oe ? 1'b0 : mosi_drv;
endmodule : rscc_board_model
`default_nettype wire

// ==== rscc_pkg.sv ====
// package for the reset strap capture block
// assumes a single 25 MHz clock domain and active-low async reset
package rscc_pkg;

  // ****************************************
  // strap and selection encodings
  // ****************************************
  localparam logic [1:0] RSCC_IF_TWI_A = 2'h0;
  localparam logic [1:0] RSCC_IF_TWI_B = 2'h1;
  localparam logic [1:0] RSCC_IF_TWI_C = 2'h2;
  localparam logic [1:0] RSCC_IF_SER = 2'h3;
  localparam logic [6:0] RSCC_TWI_ADDR_A = 7'h6C;
  localparam logic [6:0] RSCC_TWI_ADDR_B = 7'h6D;
  localparam logic [6:0] RSCC_TWI_ADDR_C = 7'h6E;
  localparam logic [1:0] RSCC_REF_XTAL = 2'h1;
  localparam logic [1:0] RSCC_REF_SE = 2'h2;
  localparam logic [4:0] RSCC_STATUS_RST = 5'h00;
  localparam logic [1:0] RSCC_REF_RST = 2'h0;

  // ****************************************
  // output formats and timing
  // ****************************************
  localparam logic [1:0] RSCC_FMT_OFF = 2'h0;
  localparam logic [1:0] RSCC_FMT_CML = 2'h1;
  localparam logic [1:0] RSCC_FMT_HSTL = 2'h2;
  localparam logic [1:0] RSCC_FMT_CMOS = 2'h3;
  localparam int RSCC_CLK_MHZ = 25;
  localparam int RSCC_READY_NS = 1000;
  localparam int RSCC_READY_CYC = (RSCC_READY_NS * RSCC_CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic test;
    logic [1:0] auto_cfg;
    logic [1:0] host_if;
  } rscc_straps_t;

  typedef struct packed {
    logic [1:0] fmt_one;
    logic [1:0] fmt_two;
    logic [1:0] fmt_three;
  } rscc_out_cfg_t;

endpackage : rscc_pkg

// ==== rscc_top.sv ====
// reset strap capture and configuration decode
// assumes straps and host pins arrive asynchronously; a host core sits outside
`timescale 1ns/100ps
`default_nettype none

module rscc_top
  import rscc_pkg::*;
#(
  parameter int READY_CYC = RSCC_READY_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic test_strap,
  input wire logic auto_config_strap_lo,
  input wire logic auto_config_strap_hi,
  input wire logic host_if_strap_lo_in,
  input wire logic host_if_strap_hi_in,
  output logic host_if_strap_hi_out,
  output logic host_if_strap_hi_oe,
  input wire logic sda_mosi_in,
  output logic sda_mosi_out,
  output logic sda_mosi_oe,
  input wire logic ser_read_data,
  input wire logic ser_read_active,
  input wire logic twi_drive_low,
  output logic cs_n,
  output logic mosi,
  output logic sda,
  output rscc_straps_t strap_capture_status,
  output logic capture_done,
  output logic test_mode,
  output logic ser_mode,
  output logic twi_mode,
  output logic [6:0] twi_addr,
  output rscc_out_cfg_t out_cfg,
  output logic [1:0] ref_input_select,
  output logic osc_a_se_en,
  output logic osc_xtal_en,
  output logic ready
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  // capture is on the third clock after release, not on the async edge itself;
  // straps are static around release so the skew is harmless
  logic [4:0] raw_pins;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [1:0] rel_q;
  // shared data pin is live after release, so it gets its own pair
  logic [1:0] dat_sync_q;
  assign raw_pins = {test_strap, auto_config_strap_hi, auto_config_strap_lo,
                     host_if_strap_hi_in, host_if_strap_lo_in};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      rel_q <= 2'h0;
      dat_sync_q <= 2'h3;
    end else begin
      sync1_q <= raw_pins;
      sync2_q <= sync1_q;
      rel_q <= {rel_q[0], 1'b1};
      dat_sync_q <= {dat_sync_q[0], sda_mosi_in};
    end
  end

  // ****************************************
  // strap capture
  // ****************************************
  rscc_straps_t status_d;
  rscc_straps_t status_q;
  logic done_d;
  logic done_q;

  always_comb begin
    status_d = status_q;
    done_d = done_q;
    if (rel_q[1] && !done_q) begin
      status_d = rscc_straps_t'(sync2_q);
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= rscc_straps_t'(RSCC_STATUS_RST);
      done_q <= 1'b0;
    end else begin
      status_q <= status_d;
      done_q <= done_d;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  rscc_out_cfg_t cfg_d;
  rscc_out_cfg_t cfg_q;
  logic [6:0] addr_d;
  logic [6:0] addr_q;
  logic [1:0] ref_d;
  logic [1:0] ref_q;

  always_comb begin
    cfg_d = cfg_q;
    addr_d = addr_q;
    ref_d = ref_q;
    if (rel_q[1] && !done_q) begin
      ref_d = RSCC_REF_XTAL;
      case (sync2_q[1:0])
        RSCC_IF_TWI_A: addr_d = RSCC_TWI_ADDR_A;
        RSCC_IF_TWI_B: addr_d = RSCC_TWI_ADDR_B;
        RSCC_IF_TWI_C: addr_d = RSCC_TWI_ADDR_C;
        default: addr_d = 7'h00;
      endcase
      case (sync2_q[3:2])
        2'h0: cfg_d = '{RSCC_FMT_CML, RSCC_FMT_OFF, RSCC_FMT_OFF};
        2'h1: cfg_d = '{RSCC_FMT_CML, RSCC_FMT_CML, RSCC_FMT_OFF};
        2'h2: cfg_d = '{RSCC_FMT_CML, RSCC_FMT_HSTL, RSCC_FMT_OFF};
        default: cfg_d = '{RSCC_FMT_CML, RSCC_FMT_CML, RSCC_FMT_CMOS};
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= '{RSCC_FMT_OFF, RSCC_FMT_OFF, RSCC_FMT_OFF};
      addr_q <= 7'h00;
      ref_q <= RSCC_REF_RST;
    end else begin
      cfg_q <= cfg_d;
      addr_q <= addr_d;
      ref_q <= ref_d;
    end
  end

  assign strap_capture_status = status_q;
  assign capture_done = done_q;
  assign out_cfg = cfg_q;
  assign twi_addr = addr_q;
  assign ref_input_select = ref_q;
  assign osc_a_se_en = (ref_q == RSCC_REF_SE);
  assign osc_xtal_en = (ref_q == RSCC_REF_XTAL);
  assign test_mode = done_q && status_q.test;
  assign ser_mode = done_q && (status_q.host_if == RSCC_IF_SER);
  assign twi_mode = done_q && (status_q.host_if != RSCC_IF_SER);

  // ****************************************
  // shared pins after reset
  // ****************************************
  // output enables gated by done_q, which reset clears, so no drive during reset
  always_comb begin
    host_if_strap_hi_out = ser_read_data;
    host_if_strap_hi_oe = ser_mode && ser_read_active;
    sda_mosi_out = 1'b0;
    sda_mosi_oe = twi_mode && twi_drive_low;
  end

  assign cs_n = ser_mode ? sync2_q[0] : 1'b1;
  assign mosi = ser_mode ? dat_sync_q[1] : 1'b0;
  assign sda = twi_mode ? dat_sync_q[1] : 1'b1;

  // ****************************************
  // ready delay
  // ****************************************
  logic [15:0] rdy_cnt_d;
  logic [15:0] rdy_cnt_q;
  logic ready_d;
  logic ready_q;

  always_comb begin
    rdy_cnt_d = rdy_cnt_q;
    ready_d = ready_q;
    if (done_q && !ready_q) begin
      if (rdy_cnt_q >= 16'(READY_CYC - 1)) begin
        ready_d = 1'b1;
      end else begin
        rdy_cnt_d = rdy_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_cnt_q <= 16'h0000;
      ready_q <= 1'b0;
    end else begin
      rdy_cnt_q <= rdy_cnt_d;
      ready_q <= ready_d;
    end
  end

  assign ready = ready_q;

  // ****************************************
  // checks
  // ****************************************
  property p_hold_status;
    @(posedge clk) disable iff (!nrst) done_q |=> $stable(status_q);
  endproperty
  a_hold_status: assert property (p_hold_status) else $error("status changed");

  property p_capture;
    @(posedge clk) disable iff (!nrst)
      (rel_q[1] && !done_q) |=> (status_q == $past(sync2_q));
  endproperty
  a_capture: assert property (p_capture) else $error("bad capture");

  property p_no_drive;
    @(posedge clk) disable iff (!nrst)
      !done_q |-> !host_if_strap_hi_oe && !sda_mosi_oe;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven early");

  property p_addr;
    @(posedge clk) disable iff (!nrst)
      (done_q && status_q.host_if == RSCC_IF_TWI_B) |-> twi_addr == RSCC_TWI_ADDR_B;
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");

  property p_cfg3;
    @(posedge clk) disable iff (!nrst)
      (done_q && status_q.auto_cfg == 2'h3) |-> out_cfg.fmt_three == RSCC_FMT_CMOS;
  endproperty
  a_cfg3: assert property (p_cfg3) else $error("bad config");

  property p_xtal;
    @(posedge clk) disable iff (!nrst) done_q |-> osc_xtal_en && !osc_a_se_en;
  endproperty
  a_xtal: assert property (p_xtal) else $error("reference not crystal");

  property p_ready_low;
    @(posedge clk) disable iff (!nrst) $rose(done_q) |-> !ready [*2];
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready too soon");

  property p_ready_on;
    @(posedge clk) disable iff (!nrst) $rose(done_q) |-> ##[1:40] ready;
  endproperty
  a_ready_on: assert property (p_ready_on) else $error("ready late");

  property p_test;
    @(posedge clk) disable iff (!nrst) test_mode |-> status_q.test && done_q;
  endproperty
  a_test: assert property (p_test) else $error("bad test mode");

  property p_cs;
    @(posedge clk) disable iff (!nrst) !ser_mode |-> cs_n;
  endproperty
  a_cs: assert property (p_cs) else $error("select outside serial mode");

  property p_addr_all;
    @(posedge clk) disable iff (!nrst)
      twi_mode |-> twi_addr == RSCC_TWI_ADDR_A + 7'(status_q.host_if);
  endproperty
  a_addr_all: assert property (p_addr_all) else $error("bad two-wire address");

  property p_mode_excl;
    @(posedge clk) disable iff (!nrst) done_q |-> ser_mode != twi_mode;
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("modes overlap");

  property p_cfg2;
    @(posedge clk) disable iff (!nrst)
      (done_q && status_q.auto_cfg == 2'h2) |-> out_cfg.fmt_two == RSCC_FMT_HSTL;
  endproperty
  a_cfg2: assert property (p_cfg2) else $error("bad second output");

  property p_hold_decode;
    @(posedge clk) disable iff (!nrst)
      done_q |=> $stable(out_cfg) && $stable(twi_addr) && $stable(ref_input_select);
  endproperty
  a_hold_decode: assert property (p_hold_decode) else $error("decode changed");

  property p_twi_release;
    @(posedge clk) disable iff (!nrst) twi_mode |-> !host_if_strap_hi_oe;
  endproperty
  a_twi_release: assert property (p_twi_release) else $error("read pin driven");

  property p_ref_one;
    @(posedge clk) disable iff (!nrst) !(osc_a_se_en && osc_xtal_en);
  endproperty
  a_ref_one: assert property (p_ref_one) else $error("both reference paths on");

endmodule : rscc_top

`default_nettype wire

// ==== test_reset_strap_config_capture.sv ====
// self-checking bench for the strap capture block
// assumes rscc_pkg and the board model are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_reset_strap_config_capture;
  import rscc_pkg::*;
  localparam int RDY = 4;
  logic clk = 0;
  logic nrst = 0;
  rscc_straps_t straps = '0;
  logic cs_n_drv = 1, mosi_drv = 1, rd_data = 0, rd_act = 0, drv_low = 0;
  logic test_pin, ac_lo, ac_hi, if_lo, if_hi, sda_pin, hi_out, hi_oe, sda_oe;
  logic cs_n, mosi, sda, done, test_mode, ser_mode, twi_mode, se_en, xtal_en, ready;
  rscc_straps_t status;
  logic [6:0] twi_addr, ea;
  rscc_out_cfg_t out_cfg, ec;
  logic [1:0] ref_sel, hif, ac;
  logic [31:0] lfsr = 32'h0582;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  // ****************************************
  // dut and far side
  // ****************************************
  rscc_top #(.READY_CYC(RDY)) i_dut (.clk(clk), .nrst(nrst), .test_strap(test_pin),
    .auto_config_strap_lo(ac_lo), .auto_config_strap_hi(ac_hi),
    .host_if_strap_lo_in(if_lo), .host_if_strap_hi_in(if_hi),
    .host_if_strap_hi_out(hi_out), .host_if_strap_hi_oe(hi_oe), .sda_mosi_in(sda_pin),
    .sda_mosi_out(), .sda_mosi_oe(sda_oe), .ser_read_data(rd_data),
    .ser_read_active(rd_act), .twi_drive_low(drv_low), .cs_n(cs_n), .mosi(mosi),
    .sda(sda), .strap_capture_status(status), .capture_done(done),
    .test_mode(test_mode), .ser_mode(ser_mode), .twi_mode(twi_mode),
    .twi_addr(twi_addr), .out_cfg(out_cfg), .ref_input_select(ref_sel),
    .osc_a_se_en(se_en), .osc_xtal_en(xtal_en), .ready(ready));
  rscc_board_model i_board (.nrst(nrst), .straps(straps), .cs_n_drv(cs_n_drv),
    .mosi_drv(mosi_drv), .hi_out(hi_out), .hi_oe(hi_oe), .sda_oe(sda_oe),
    .test_pin(test_pin), .ac_lo_pin(ac_lo), .ac_hi_pin(ac_hi), .if_lo_pin(if_lo),
    .if_hi_pin(if_hi), .sda_pin(sda_pin));

  // ****************************************
  // helpers
  // ****************************************
  always #20 clk = ~clk;

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // a hang is stopped at 2000 cycles, over four times the sweep of about 450 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ****************************************
  // sweep every strap pattern, reset between each
  // ****************************************
  initial begin
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      straps = rscc_straps_t'(i[4:0]);
      nrst = 0;
      cs_n_drv = 1;
      mosi_drv = 1;
      rd_act = 0;
      drv_low = 0;
      repeat (3) @(negedge clk);
      chk(!done && !ready && !hi_oe && !sda_oe && cs_n === 1, "reset state");
      nrst = 1;
      repeat (2) @(negedge clk);
      chk(done === 1'b0, "capture early");
      @(negedge clk);
      chk(done === 1'b1 && status === rscc_straps_t'(i[4:0]), "status");
      straps = rscc_straps_t'(lfsr[4:0]);
      lfsr = nxt(lfsr);
      hif = i[1:0];
      ac = i[3:2];
      ea = (hif == 2'h3) ? 7'h00 : RSCC_TWI_ADDR_A + 7'(hif);
      ec.fmt_one = RSCC_FMT_CML;
      ec.fmt_two = (ac == 2'h0) ? RSCC_FMT_OFF : (ac == 2'h2) ? RSCC_FMT_HSTL : RSCC_FMT_CML;
      ec.fmt_three = (ac == 2'h3) ? RSCC_FMT_CMOS : RSCC_FMT_OFF;
      chk(test_mode === i[4], "test mode");
      chk(ser_mode === (hif == 2'h3) && twi_mode === (hif != 2'h3), "mode");
      chk(twi_addr === ea, "address");
      chk(out_cfg === ec, "outputs");
      chk(ref_sel === RSCC_REF_XTAL && xtal_en === 1 && se_en === 0, "ref");
      repeat (RDY - 1) @(negedge clk);
      chk(ready === 1'b0, "ready early");
      @(negedge clk);
      chk(ready === 1'b1 && status === rscc_straps_t'(i[4:0]), "ready");
      cs_n_drv = lfsr[0];
      mosi_drv = lfsr[1];
      rd_data = lfsr[2];
      lfsr = nxt(lfsr);
      rd_act = 1;
      drv_low = 1;
      repeat (3) @(negedge clk);
      if (hif == 2'h3) begin
        chk(if_hi === rd_data && cs_n === cs_n_drv && mosi === mosi_drv, "serial");
      end else begin
        chk(!hi_oe && sda_pin === 0 && sda === 0 && cs_n === 1 && mosi === 0, "twi");
      end
    end
    give_verdict();
  end
endmodule : test_reset_strap_config_capture
`default_nettype wire
